// ==== pkg/wdg_pkg.sv ====
// package: register map, fields, reset values and timing for the watchdog
package wdg_pkg;
  // register word byte addresses on the avalon slave
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_IEN = 4'hC;
  // address bit 4 selects the second bank
  localparam logic [4:0] ADDR_ICLR = 5'h10;
  // control word fields
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_RUN_LSB = 8;
  localparam int CTRL_CLK_LSB = 6;
  localparam int CTRL_SLP_LSB = 1;
  localparam int CTRL_WIN_BIT = 0;
  // service key
  localparam logic [15:0] SERVICE_KEY = 16'h5743;
  // clock select encodings
  localparam logic [1:0] CLK_LOW_POWER_RC_OSC = 2'h3;
  localparam logic [1:0] CLK_FAST = 2'h2;
  localparam logic [1:0] CLK_RSVD = 2'h1;
  localparam logic [1:0] CLK_SYS = 2'h0;
  // status bits
  localparam int ST_TIMEOUT = 0;
  localparam int ST_EARLY = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_W = 3;
  // reset pulse length and the dead cycle after a disable
  localparam int RESET_PULSE_CYC = 4;
  localparam int OFF_GAP_CYC = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // state machine
  typedef enum logic [2:0] {
    WDG_IDLE = 3'b001,
    WDG_RUN = 3'b010,
    WDG_RESET = 3'b100
  } wdg_state_e;
endpackage

// ==== pkg/wdg_tick_if.sv ====
// interface: tick selection between watchdog core and its counter
`timescale 1ns/100ps
`default_nettype none
interface wdg_tick_if;
  logic tick;
  logic clear;
  logic [4:0] div;
  logic expired;
  logic window_open;
  modport core (output tick, output clear, output div,
    input expired, input window_open);
  modport counter (input tick, input clear, input div,
    output expired, output window_open);
endinterface
`default_nettype wire

// ==== src/wdg_counter.sv ====
// module: postscaled time-out counter with window detection
`timescale 1ns/100ps
`default_nettype none
module wdg_counter (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  wdg_tick_if.counter tif
);
  typedef struct packed {
    logic [30:0] cnt;
    logic expired;
  } wdg_cnt_s;
  wdg_cnt_s s_q, s_d;
  logic [30:0] limit;
  always_comb begin
    // divide by 2^(div+1): terminal count is that value minus one
    limit = (31'h0000_0002 << tif.div) - 31'h0000_0001;
    s_d = s_q;
    s_d.expired = 1'b0;
    if (tif.clear) begin
      s_d.cnt = '0;
    end else if (tif.tick) begin
      if (s_q.cnt >= limit) begin
        s_d.cnt = '0;
        s_d.expired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 31'h0000_0001;
      end
    end
  end
  // window opens for the final quarter of the period
  assign tif.window_open = (s_q.cnt >= (limit - (limit >> 2)));
  assign tif.expired = s_q.expired;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else if (en_in) begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ==== src/wdg_top.sv ====
// module: watchdog with avalon register slave, key service and interrupts
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - low-power oscillator in sleep or idle; otherwise selected clock
// - expiry outside sleep and idle resets device and sets timeout flag
// - expiry in sleep or idle wakes device
// - enable bit starts; clears only if software-enabled
// - enable reads one whenever the watchdog runs
// - run divider field selects 2^(n+1)
// - sleep divider field, same encoding
// - clock select: 11 low-power, 10 fast, 00 system
// - divider and clock fields read fuse values
// - window enable bit selects windowed servicing
// - window fuse set forces window bit high
// - key 0x5743 in one 16-bit write restarts
module wdg_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic por_in,
  input wire logic fuse_on_in,
  input wire logic [4:0] fuse_run_div_in,
  input wire logic [4:0] fuse_sleep_div_in,
  input wire logic [1:0] fuse_clk_sel_in,
  input wire logic fuse_window_in,
  input wire logic low_power_rc_osc_tick_in,
  input wire logic fast_rc_osc_tick_in,
  input wire logic sleep_in,
  input wire logic idle_in,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic device_reset_out,
  output logic wake_out,
  output logic timeout_reset_flag_out,
  output logic irq_out
);
  typedef struct packed {
    wdg_pkg::wdg_state_e st;
    logic sw_on;
    logic win_sw;
    logic [4:0] run_div;
    logic [4:0] slp_div;
    logic [1:0] clk_sel;
    logic fuse_on;
    logic fuse_win;
    logic flag;
    logic [wdg_pkg::ST_W-1:0] stat;
    logic [wdg_pkg::ST_W-1:0] ien;
    logic [2:0] rst_cnt;
    logic gap;
    logic ack;
    logic [31:0] rdata;
    logic reset_out;
    logic wake;
    logic irq;
  } wdg_top_s;
  wdg_top_s s_q, s_d;
  wdg_tick_if tif ();
  logic running, saving, acc, wr16, key_ok;
  logic [15:0] ctrl_rd;

  wdg_counter u_wdg_counter (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .en_in(clk_en_in),
    .tif(tif)
  );

  always_comb begin
    running = s_q.fuse_on | s_q.sw_on;
    saving = sleep_in | idle_in;
    acc = (avs_read | avs_write) & ~s_q.ack & ~s_q.gap;
    wr16 = (avs_byteenable[1:0] == 2'b11);
    key_ok = wr16 && (avs_writedata[15:0] == wdg_pkg::SERVICE_KEY);
    ctrl_rd = '0;
    ctrl_rd[wdg_pkg::CTRL_ON_BIT] = running;
    ctrl_rd[wdg_pkg::CTRL_RUN_LSB +: 5] = s_q.run_div;
    ctrl_rd[wdg_pkg::CTRL_CLK_LSB +: 2] = s_q.clk_sel;
    ctrl_rd[wdg_pkg::CTRL_SLP_LSB +: 5] = s_q.slp_div;
    ctrl_rd[wdg_pkg::CTRL_WIN_BIT] = s_q.fuse_win | s_q.win_sw;
    // tick source: low-power oscillator when saving, else run select
    if (saving) begin
      tif.tick = low_power_rc_osc_tick_in;
      tif.div = s_q.slp_div;
    end else begin
      tif.div = s_q.run_div;
      case (s_q.clk_sel)
        wdg_pkg::CLK_LOW_POWER_RC_OSC: tif.tick = low_power_rc_osc_tick_in;
        wdg_pkg::CLK_FAST: tif.tick = fast_rc_osc_tick_in;
        wdg_pkg::CLK_SYS: tif.tick = 1'b1;
        default: tif.tick = 1'b0; // reserved: counter stalls
      endcase
    end
    tif.tick = tif.tick & running & (s_q.st == wdg_pkg::WDG_RUN);
    tif.clear = ~running;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.gap = 1'b0;
    s_d.wake = 1'b0;
    if (por_in) begin
      // fuse capture on power-on reset, clocked so no port feeds reset
      s_d.run_div = fuse_run_div_in;
      s_d.slp_div = fuse_sleep_div_in;
      s_d.clk_sel = fuse_clk_sel_in;
      s_d.fuse_on = fuse_on_in;
      s_d.fuse_win = fuse_window_in;
      s_d.flag = 1'b0;
      s_d.sw_on = 1'b0;
      s_d.win_sw = 1'b0;
    end
    // bus access: one wait cycle, answer on the ack cycle
    if (acc) begin
      s_d.ack = 1'b1;
      s_d.rdata = '0;
      if (avs_read) begin
        case (avs_address)
          {1'b0, wdg_pkg::ADDR_CTRL}: s_d.rdata = {16'h0000, ctrl_rd};
          {1'b0, wdg_pkg::ADDR_STAT}: s_d.rdata = {29'h0, s_q.stat};
          {1'b0, wdg_pkg::ADDR_IEN}: s_d.rdata = {29'h0, s_q.ien};
          default: s_d.rdata = '0;
        endcase
      end else begin
        case (avs_address)
          {1'b0, wdg_pkg::ADDR_CTRL}: begin
            if (avs_byteenable[1]) begin
              // fuse-enabled watchdog keeps running via fuse_on
              s_d.sw_on = avs_writedata[wdg_pkg::CTRL_ON_BIT];
              if (s_q.sw_on && !avs_writedata[wdg_pkg::CTRL_ON_BIT]) begin
                s_d.gap = 1'b1;
              end
            end
            if (avs_byteenable[0]) begin
              s_d.win_sw = avs_writedata[wdg_pkg::CTRL_WIN_BIT];
            end
          end
          {1'b0, wdg_pkg::ADDR_KEY}: begin
            if (key_ok && running) begin
              if ((s_q.fuse_win | s_q.win_sw) && !tif.window_open) begin
                s_d.st = wdg_pkg::WDG_RESET;
                s_d.rst_cnt = '0;
                s_d.stat[wdg_pkg::ST_EARLY] = 1'b1;
              end else begin
                tif.clear = 1'b1;
              end
            end
          end
          {1'b0, wdg_pkg::ADDR_IEN}: s_d.ien = avs_writedata[2:0];
          wdg_pkg::ADDR_ICLR: s_d.stat = s_q.stat & ~avs_writedata[2:0];
          default: s_d.rdata = '0;
        endcase
      end
    end
    case (s_q.st)
      wdg_pkg::WDG_IDLE: begin
        if (running) begin
          s_d.st = wdg_pkg::WDG_RUN;
        end
      end
      wdg_pkg::WDG_RUN: begin
        if (!running) begin
          s_d.st = wdg_pkg::WDG_IDLE;
        end else if (tif.expired) begin
          if (saving) begin
            s_d.wake = 1'b1;
            s_d.stat[wdg_pkg::ST_WAKE] = 1'b1;
          end else begin
            s_d.st = wdg_pkg::WDG_RESET;
            s_d.rst_cnt = '0;
            s_d.stat[wdg_pkg::ST_TIMEOUT] = 1'b1;
          end
        end
      end
      wdg_pkg::WDG_RESET: begin
        s_d.flag = 1'b1;
        s_d.sw_on = 1'b0;
        tif.clear = 1'b1;
        s_d.rst_cnt = s_q.rst_cnt + 3'h1;
        if (s_q.rst_cnt == 3'(wdg_pkg::RESET_PULSE_CYC - 1)) begin
          s_d.st = wdg_pkg::WDG_IDLE;
        end
      end
      default: s_d.st = wdg_pkg::WDG_IDLE;
    endcase
    s_d.reset_out = (s_d.st == wdg_pkg::WDG_RESET);
    s_d.irq = |(s_d.stat & s_d.ien);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.st <= wdg_pkg::WDG_IDLE;
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = ~s_q.ack;
  assign device_reset_out = s_q.reset_out;
  assign wake_out = s_q.wake;
  assign timeout_reset_flag_out = s_q.flag;
  assign irq_out = s_q.irq;
endmodule
`default_nettype wire

// ==== verification/wdg_props.sv ====
// checker: port-level properties of the watchdog
`timescale 1ns/100ps
`default_nettype none
module wdg_props (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_in,
  input wire logic sleep_in,
  input wire logic idle_in,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic device_reset_out,
  input wire logic wake_out,
  input wire logic timeout_reset_flag_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rst_len;
    $rose(device_reset_out) |-> device_reset_out[*4] ##1 !device_reset_out;
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong");
  property p_flag_set;
    $rose(device_reset_out) |-> ##[0:2] timeout_reset_flag_out;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("timeout flag not set by reset");
  property p_flag_cause;
    $rose(timeout_reset_flag_out) |-> ##[0:1] device_reset_out;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("timeout flag set without reset");
  property p_flag_hold;
    $fell(timeout_reset_flag_out) |-> $past(por_in);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("timeout flag cleared without power-on");
  property p_wake_cause;
    wake_out |-> $past(sleep_in || idle_in);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake outside power save");
  property p_wake_pulse;
    wake_out |=> !wake_out;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake longer than one cycle");
  property p_ack_cause;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
endmodule
bind wdg_top wdg_props u_wdg_props (.clk_in, .rst_n_in, .por_in, .sleep_in,
  .idle_in, .avs_read, .avs_write, .avs_waitrequest, .device_reset_out,
  .wake_out, .timeout_reset_flag_out);
`default_nettype wire

// ==== verification/wdg_top_bench.sv ====
// bench: self-checking scenarios for the watchdog
`timescale 1ns/100ps
`default_nettype none
module wdg_top_bench;
  logic clk_in = 1'b0, rst_n_in = 1'b0, por_in = 1'b0, sleep_in = 1'b0;
  logic fuse_on_in = 1'b0, fuse_window_in = 1'b0;
  logic low_power_rc_osc_tick_in = 1'b0, fast_rc_osc_tick_in = 1'b0;
  logic idle_in = 1'b0;
  logic [1:0] fuse_clk_sel_in = wdg_pkg::CLK_SYS;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [4:0] fuse_run_div_in = 5'h00, avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic avs_waitrequest, device_reset_out, wake_out;
  logic timeout_reset_flag_out, irq_out;
  logic rs_seen = 1'b0, wk_seen = 1'b0;
  int miscompares = 0, tests_run = 0;
  // sleep divider fixed; the run clock follows the fuse select
  wdg_top u_wdg_top (.clk_in, .rst_n_in, .clk_en_in(1'b1), .por_in,
    .fuse_on_in, .fuse_run_div_in, .fuse_sleep_div_in(5'h01),
    .fuse_clk_sel_in, .fuse_window_in,
    .low_power_rc_osc_tick_in, .fast_rc_osc_tick_in, .sleep_in,
    .idle_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .device_reset_out,
    .wake_out, .timeout_reset_flag_out, .irq_out);
  always #25 clk_in = ~clk_in;
  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge clk_in);
      rs_seen |= device_reset_out;
      wk_seen |= wake_out;
    end
  endtask
  // trailing idle edge keeps the access after a disable off the dead cycle
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [15:0] d, input logic [3:0] be, output logic [15:0] q);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk_in);
      rs_seen |= device_reset_out;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, 4'hf, q);
    chk(q, e);
  endtask
  task automatic por(input logic [4:0] dv, input logic win, input logic on);
    fuse_run_div_in <= dv;
    fuse_window_in <= win;
    fuse_on_in <= on;
    por_in <= 1'b1;
    @(posedge clk_in);
    por_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic s_regs;
    por(5'h02, 1'b0, 1'b0);
    rd(5'h00, 16'h0202);
    wr(5'h00, 16'hffff);
    rd(5'h00, 16'h8203);
    wr(5'h00, 16'h0000);
    rd(5'h00, 16'h0202);
    rd(5'h14, 16'h0000);
    rs_seen = 1'b0;
    watch(30);
    chk(16'(rs_seen), 16'h0000);
  endtask
  task automatic s_service;
    logic [15:0] q;
    wr(5'h10, 16'h0007);
    wr(5'h0c, 16'h0000);
    wr(5'h00, 16'h8000);
    rs_seen = 1'b0;
    repeat (8) wr(5'h04, 16'h5743);
    chk(16'(rs_seen), 16'h0000);
    repeat (3) begin
      bus(1'b1, 5'h04, 16'h5744, 4'hf, q);
      bus(1'b1, 5'h04, 16'h5743, 4'h1, q);
    end
    chk(16'(rs_seen), 16'h0001);
    watch(8);
    chk(16'(timeout_reset_flag_out), 16'h0001);
    rd(5'h08, 16'h0001);
    chk(16'(irq_out), 16'h0000);
    wr(5'h0c, 16'h0001);
    watch(2);
    chk(16'(irq_out), 16'h0001);
    wr(5'h10, 16'h0001);
    watch(2);
    chk(16'(irq_out), 16'h0000);
    rd(5'h08, 16'h0000);
  endtask
  task automatic s_window;
    por(5'h03, 1'b1, 1'b1);
    wr(5'h10, 16'h0007);
    rs_seen = 1'b0;
    wr(5'h04, 16'h5743);
    watch(8);
    chk(16'(rs_seen), 16'h0001);
    rd(5'h08, 16'h0002);
    rd(5'h00, 16'h8303);
    wr(5'h00, 16'h0000);
    rd(5'h00, 16'h8303);
    rs_seen = 1'b0;
    watch(40);
    chk(16'(rs_seen), 16'h0001);
  endtask
  // run clock select: only the chosen source advances the count
  task automatic s_clock;
    fuse_clk_sel_in <= wdg_pkg::CLK_FAST;
    low_power_rc_osc_tick_in <= 1'b1;
    por(5'h00, 1'b0, 1'b1);
    rd(5'h00, 16'h8082);
    watch(8);
    rs_seen = 1'b0;
    watch(20);
    chk(16'(rs_seen), 16'h0000);
    fast_rc_osc_tick_in <= 1'b1;
    watch(20);
    chk(16'(rs_seen), 16'h0001);
    low_power_rc_osc_tick_in <= 1'b0;
    fuse_clk_sel_in <= wdg_pkg::CLK_LOW_POWER_RC_OSC;
    por(5'h00, 1'b0, 1'b1);
    watch(8);
    rs_seen = 1'b0;
    watch(20);
    chk(16'(rs_seen), 16'h0000);
    low_power_rc_osc_tick_in <= 1'b1;
    watch(20);
    chk(16'(rs_seen), 16'h0001);
    fuse_clk_sel_in <= wdg_pkg::CLK_RSVD;
    por(5'h00, 1'b0, 1'b1);
    watch(8);
    rs_seen = 1'b0;
    watch(20);
    chk(16'(rs_seen), 16'h0000);
    fuse_clk_sel_in <= wdg_pkg::CLK_SYS;
    low_power_rc_osc_tick_in <= 1'b0;
    fast_rc_osc_tick_in <= 1'b0;
  endtask
  task automatic s_sleep;
    por(5'h02, 1'b0, 1'b0);
    chk(16'(timeout_reset_flag_out), 16'h0000);
    sleep_in <= 1'b1;
    wr(5'h00, 16'h8000);
    wk_seen = 1'b0;
    watch(30);
    chk(16'(wk_seen), 16'h0000);
    low_power_rc_osc_tick_in <= 1'b1;
    watch(20);
    chk(16'(wk_seen), 16'h0001);
    sleep_in <= 1'b0;
    idle_in <= 1'b1;
    wk_seen = 1'b0;
    watch(20);
    chk(16'(wk_seen), 16'h0001);
    low_power_rc_osc_tick_in <= 1'b0;
    idle_in <= 1'b0;
  endtask
  initial begin
    #100us;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    s_regs;
    s_service;
    s_window;
    s_clock;
    s_sleep;
    tally_and_finish;
  end
endmodule
`default_nettype wire
